// *** wst_defines.svh ***
// Register offsets, fields, reset values and rates for the windowed service timer
`ifndef WST_DEFINES_SVH
`define WST_DEFINES_SVH

// ==========================================================
// Register offsets
`define WST_ADDR_W        4
`define WST_OFF_CTRL      4'h0
`define WST_OFF_RELOAD    4'h1
`define WST_OFF_WINDOW    4'h2
`define WST_OFF_SERVICE   4'h3
`define WST_OFF_COUNT     4'h4
`define WST_OFF_STATUS    4'h5

// ==========================================================
// Control fields
`define WST_CTRL_EN       0
`define WST_CTRL_SLOW     1
`define WST_CTRL_FREEZE   2
`define WST_CTRL_WIN_EN   3
`define WST_CTRL_RESET    8'h04

// ==========================================================
// Service key and defaults
`define WST_SERVICE_KEY   8'hA5
`define WST_RELOAD_RESET  8'h00
`define WST_WINDOW_RESET  8'h00

// ==========================================================
// Prescaler terminal counts (divide by 2 and by 128)
`define WST_DIV_FAST      7'h01
`define WST_DIV_SLOW      7'h7F

// ==========================================================
// Reset pulse length in cycles
`define WST_RST_PULSE     4'h8

`endif

// *** wst_pkg.sv ***
// Types for the windowed service timer
package wst_pkg;
  typedef enum logic [1:0] {
    WST_CAUSE_NONE,
    WST_CAUSE_EXPIRE,
    WST_CAUSE_EARLY
  } wst_cause_t;
endpackage : wst_pkg

// *** wst_timer.sv ***
// Windowed watchdog counter with service access and system reset request
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "wst_defines.svh"

// Operation
// RULE1: When enabled and counter overflows without service, request system reset.
// RULE2: Watchdog is disabled after reset; no counting, no reset requests.
// RULE3: Debug freeze bit defaults to one; halts counter while in debug mode.
// RULE4: Sixteen-bit counter, low byte carry increments the high byte.
// RULE5: Count rate is clock divided by 2 or divided by 128.
// RULE6: Service access loads the high byte with the reload value.
// RULE7: Service access clears the low byte at the same time.
// RULE8: Service before window boundary is a fault and requests system reset.
module wst_timer (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [`WST_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  input  wire logic                   debug_mode,
  output logic      [7:0]             rdata,
  output logic                        sys_reset_req
);

  // ==========================================================
  // Debug input synchroniser
  logic [2:0] dbg_sync_r;
  logic       dbg_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dbg_sync_r <= 3'h0;
      dbg_r      <= 1'b0;
    end else begin
      dbg_sync_r <= {dbg_sync_r[1:0], debug_mode};
      if (dbg_sync_r[1] == dbg_sync_r[2]) begin
        dbg_r <= dbg_sync_r[2];
      end
    end
  end

  // ==========================================================
  // Registers
  logic [7:0]  ctrl_r;
  logic [7:0]  reload_r;
  logic [7:0]  window_r;
  logic [15:0] count_r;
  logic [6:0]  pre_r;
  logic [3:0]  rst_cnt_r;
  wst_pkg::wst_cause_t cause_r;

  wire enabled    = ctrl_r[`WST_CTRL_EN];
  wire frozen     = ctrl_r[`WST_CTRL_FREEZE] & dbg_r;              // RULE3
  wire running    = enabled & ~frozen;
  wire [6:0] div_tc = ctrl_r[`WST_CTRL_SLOW] ? `WST_DIV_SLOW : `WST_DIV_FAST; // RULE5
  wire tick       = running & (pre_r == div_tc);
  wire ctrl_wr    = wr_en & (addr == `WST_OFF_CTRL);
  wire svc_hit    = wr_en & (addr == `WST_OFF_SERVICE) & (wdata == `WST_SERVICE_KEY);
  wire service    = svc_hit & enabled;
  // Early service only counts as fault with window checking enabled
  wire early      = service & ctrl_r[`WST_CTRL_WIN_EN] & (count_r[15:8] < window_r); // RULE8
  wire lo_carry   = &count_r[7:0];
  wire expire     = tick & lo_carry & (&count_r[15:8]);             // RULE1
  wire fault      = expire | early;
  wire resetting  = rst_cnt_r != 4'h0;

  // Register read mux
  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr)
      `WST_OFF_CTRL:   rd_mux = ctrl_r;
      `WST_OFF_RELOAD: rd_mux = reload_r;
      `WST_OFF_WINDOW: rd_mux = window_r;
      `WST_OFF_COUNT:  rd_mux = count_r[15:8];
      `WST_OFF_STATUS: rd_mux = {5'h00, frozen, cause_r};
      default:         rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // Control and configuration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r   <= `WST_CTRL_RESET;                                  // RULE2 RULE3
      reload_r <= `WST_RELOAD_RESET;
      window_r <= `WST_WINDOW_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= wdata;
      end
      if (wr_en && addr == `WST_OFF_RELOAD) begin
        reload_r <= wdata;
      end
      if (wr_en && addr == `WST_OFF_WINDOW) begin
        window_r <= wdata;
      end
    end
  end

  // ==========================================================
  // Prescaler and counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_r   <= 7'h00;
      count_r <= 16'h0000;
    end else if (service || (ctrl_wr && !wdata[`WST_CTRL_EN])) begin
      pre_r   <= 7'h00;
      count_r <= {reload_r, 8'h00};                                 // RULE6 RULE7
    end else if (running) begin
      pre_r <= tick ? 7'h00 : pre_r + 7'h01;
      if (tick) begin
        count_r[7:0] <= count_r[7:0] + 8'h01;                       // RULE4
        if (lo_carry) begin
          count_r[15:8] <= count_r[15:8] + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Reset request and cause; cause survives to be read after reset pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rst_cnt_r     <= 4'h0;
      sys_reset_req <= 1'b0;
      cause_r       <= wst_pkg::WST_CAUSE_NONE;
      rdata         <= 8'h00;
    end else begin
      rdata <= rd_en ? rd_mux : 8'h00;
      if (fault && !resetting) begin
        rst_cnt_r     <= `WST_RST_PULSE;
        sys_reset_req <= 1'b1;                                      // RULE1 RULE8
        cause_r       <= early ? wst_pkg::WST_CAUSE_EARLY : wst_pkg::WST_CAUSE_EXPIRE;
      end else if (resetting) begin
        rst_cnt_r     <= rst_cnt_r - 4'h1;
        sys_reset_req <= rst_cnt_r != 4'h1;
      end
    end
  end

  // ==========================================================
  // Assertions
  property p_no_reset_disabled;
    @(posedge ref_clk) disable iff (rst)
      !enabled && !resetting |=> !sys_reset_req;
  endproperty
  a_no_reset_disabled: assert property (p_no_reset_disabled) // RULE2
    else $error("reset request while disabled");

  property p_expire_reset;
    @(posedge ref_clk) disable iff (rst)
      expire && !resetting |=> sys_reset_req ##0 cause_r == wst_pkg::WST_CAUSE_EXPIRE;
  endproperty
  a_expire_reset: assert property (p_expire_reset) // RULE1
    else $error("expiry did not request reset");

  property p_frozen_hold;
    @(posedge ref_clk) disable iff (rst)
      frozen && !service && !ctrl_wr |=> count_r == $past(count_r);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) // RULE3
    else $error("counter moved while frozen");

  property p_carry;
    @(posedge ref_clk) disable iff (rst)
      tick && lo_carry && !service && !ctrl_wr |=>
        count_r[15:8] == $past(count_r[15:8]) + 8'h01 && count_r[7:0] == 8'h00;
  endproperty
  a_carry: assert property (p_carry) // RULE4
    else $error("low byte carry not propagated");

  property p_fast_rate;
    @(posedge ref_clk) disable iff (rst)
      tick && !ctrl_r[`WST_CTRL_SLOW] && running |=> !tick;
  endproperty
  a_fast_rate: assert property (p_fast_rate) // RULE5
    else $error("fast rate ticked twice in a row");

  property p_service_load;
    @(posedge ref_clk) disable iff (rst)
      service |=> count_r == {$past(reload_r), 8'h00};
  endproperty
  a_service_load: assert property (p_service_load) // RULE6 RULE7
    else $error("service did not reload counter");

  property p_early_fault;
    @(posedge ref_clk) disable iff (rst)
      early && !resetting |=> sys_reset_req && cause_r == wst_pkg::WST_CAUSE_EARLY;
  endproperty
  a_early_fault: assert property (p_early_fault) // RULE8
    else $error("early service not flagged");

  property p_pulse_len;
    @(posedge ref_clk) disable iff (rst)
      $rose(sys_reset_req) |-> sys_reset_req[*8] ##1 !sys_reset_req;
  endproperty
  a_pulse_len: assert property (p_pulse_len) // RULE1
    else $error("reset pulse length wrong");

  property p_disabled_hold;
    @(posedge ref_clk) disable iff (rst)
      !enabled && !ctrl_wr |=> count_r == $past(count_r);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) // RULE2
    else $error("counter moved while disabled");

  property p_reset_idle;
    @(posedge ref_clk)
      $fell(rst) |-> ctrl_r == `WST_CTRL_RESET && count_r == 16'h0000 && !sys_reset_req;
  endproperty
  a_reset_idle: assert property (p_reset_idle) // RULE2 RULE3
    else $error("state after reset not idle");

  property p_req_needs_fault;
    @(posedge ref_clk) disable iff (rst)
      !sys_reset_req && !fault |=> !sys_reset_req;
  endproperty
  a_req_needs_fault: assert property (p_req_needs_fault) // RULE1 RULE8
    else $error("reset request without a fault");

  // Service at or past the boundary must not fault
  property p_late_service_ok;
    @(posedge ref_clk) disable iff (rst)
      service && !expire && count_r[15:8] >= window_r && !resetting |=> !sys_reset_req;
  endproperty
  a_late_service_ok: assert property (p_late_service_ok) // RULE8
    else $error("service after window boundary faulted");

endmodule : wst_timer

// *** windowed_service_timer_bench.sv ***
// Self-checking bench for the windowed service timer
`timescale 1ns/100ps
`include "wst_defines.svh"
module windowed_service_timer_bench;
  logic       ref_clk       = 1'b0;
  logic       rst           = 1'b1;
  logic [3:0] addr          = 4'h0;
  logic [7:0] wdata         = 8'h00;
  logic       wr_en         = 1'b0;
  logic       rd_en         = 1'b0;
  logic       debug_mode    = 1'b0;
  logic [7:0] rdata;
  logic       sys_reset_req;
  int         num_errors    = 0;
  int         comparisons   = 0;
  int         cycles        = 0;

  always #10 ref_clk = ~ref_clk;

  wst_timer DUT (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .debug_mode(debug_mode), .rdata(rdata), .sys_reset_req(sys_reset_req));

  // ==========================================================
  // Verdict and hang guard
  task report_and_stop;
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Whole run needs about 4000 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Compares and bus cycles
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk8(rdata, e);
  endtask : rd

  task quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      #1 seen |= (sys_reset_req !== 1'b0);
    end
    chk1(seen, 1'b0);
  endtask : quiet

  // Pulse must appear within win cycles and last exactly 8
  task expect_req(input int win);
    int n;
    n = 0;
    // Step past the edge so a request launched there is already visible
    #1;
    while (sys_reset_req !== 1'b1 && n < win) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk1(sys_reset_req, 1'b1);
    n = 0;
    while (sys_reset_req === 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk8(n[7:0], {4'h0, `WST_RST_PULSE});
  endtask : expect_req

  task do_reset;
    @(posedge ref_clk);
    rst        <= 1'b1;
    debug_mode <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : do_reset

  // ==========================================================
  // Scenarios
  task t_reset;
    rd(`WST_OFF_CTRL, `WST_CTRL_RESET);
    rd(`WST_OFF_RELOAD, 8'h00);
    rd(`WST_OFF_WINDOW, 8'h00);
    wr(`WST_OFF_COUNT, 8'h55);
    wr(`WST_OFF_SERVICE, `WST_SERVICE_KEY);
    quiet(600);
    rd(`WST_OFF_COUNT, 8'h00);
    rd(`WST_OFF_STATUS, 8'h00);
    rd(4'h6, 8'h00);
  endtask : t_reset

  // Second service lands with the low byte near 200
  task t_expire;
    wr(`WST_OFF_RELOAD, 8'hFF);
    wr(`WST_OFF_CTRL, 8'h05);
    wr(`WST_OFF_SERVICE, `WST_SERVICE_KEY);
    rd(`WST_OFF_COUNT, 8'hFF);
    quiet(396);
    wr(`WST_OFF_SERVICE, `WST_SERVICE_KEY);
    quiet(500);
    expect_req(30);
    rd(`WST_OFF_STATUS, 8'h01);
  endtask : t_expire

  task t_slow;
    wr(`WST_OFF_RELOAD, 8'hFF);
    wr(`WST_OFF_CTRL, 8'h07);
    wr(`WST_OFF_SERVICE, `WST_SERVICE_KEY);
    quiet(600);
    rd(`WST_OFF_COUNT, 8'hFF);
  endtask : t_slow

  task t_freeze;
    @(posedge ref_clk);
    debug_mode <= 1'b1;
    wr(`WST_OFF_RELOAD, 8'hF0);
    wr(`WST_OFF_CTRL, 8'h05);
    wr(`WST_OFF_SERVICE, `WST_SERVICE_KEY);
    quiet(600);
    rd(`WST_OFF_COUNT, 8'hF0);
    rd(`WST_OFF_STATUS, 8'h04);
    @(posedge ref_clk);
    debug_mode <= 1'b0;
    quiet(600);
    rd(`WST_OFF_COUNT, 8'hF1);
  endtask : t_freeze

  // Service exactly at the boundary passes, one below it faults
  task t_early;
    wr(`WST_OFF_RELOAD, 8'h7F);
    wr(`WST_OFF_WINDOW, 8'h80);
    wr(`WST_OFF_CTRL, 8'h05);
    wr(`WST_OFF_SERVICE, `WST_SERVICE_KEY);
    wr(`WST_OFF_CTRL, 8'h0D);
    quiet(520);
    wr(`WST_OFF_SERVICE, `WST_SERVICE_KEY);
    quiet(20);
    rd(`WST_OFF_COUNT, 8'h7F);
    wr(`WST_OFF_SERVICE, `WST_SERVICE_KEY);
    expect_req(10);
    rd(`WST_OFF_STATUS, 8'h02);
  endtask : t_early

  initial begin
    do_reset();
    t_reset();
    do_reset();
    t_expire();
    do_reset();
    t_slow();
    do_reset();
    t_freeze();
    do_reset();
    t_early();
    report_and_stop();
  end
endmodule : windowed_service_timer_bench
